/* rtl/adcts_divider.sv */
`timescale 1ns/1ps
`default_nettype none
// programmable divider: one-cycle pulse every div input ticks
module adcts_divider #(
  parameter int W = 16
) (
  input  wire logic         i_clk_sys,
  input  wire logic         i_reset_n,
  input  wire logic         i_tick,
  input  wire logic         i_clear,
  input  wire logic [W-1:0] i_div,
  output logic              o_pulse
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  logic         wrap;

  // a divisor of zero acts as one so the pacer never stalls
  assign wrap    = i_tick && (cnt_r + W'(1) >= i_div);
  assign cnt_nxt = i_clear ? '0 : wrap ? '0 : i_tick ? cnt_r + W'(1) : cnt_r;

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt_r   <= '0;
      o_pulse <= 1'b0;
    end else begin
      cnt_r   <= cnt_nxt;
      o_pulse <= wrap && !i_clear;
    end
  end
endmodule : adcts_divider
`default_nettype wire

/* rtl/adcts_pkg.sv */
// Summary of operation
// - status word 0x38: bit3 timer, bit2 window-done
// - bit1 fifo half full, bit0 external trigger
// - ready flag low while converting, high after
// - reading result low byte clears ready flag
// - conversion finishes within 8 us of trigger
// - external select ignores software and pacer triggers
// - trigger source chosen by control register bits
// - with ext and pacer bits clear, any write to trigger register starts conversion
// - two cascaded counters make periodic pacer triggers
// - burst conversions at base rate over c1
// - scans start at base over c1 times c2
// - sample-hold scan adds one extra tick first
// - hold strobe driven out for external sample-hold
// - burst modes chosen by function register bits
// - external trigger rising edge starts one conversion, or one burst in burst mode
// - transfer method chosen by control register bits
// - interrupt transfer raises request at conversion end
// - bus-master mode queues results into fifo
// - writes to 0x38 set four interrupt enables
package adcts_pkg;
  localparam logic [7:0] OFS_CTRL     = 8'h18;
  localparam logic [7:0] OFS_SWTRIG   = 8'h20;
  localparam logic [7:0] OFS_BURSTNUM = 8'h28;
  localparam logic [7:0] OFS_FUNC     = 8'h30;
  localparam logic [7:0] OFS_IRQ      = 8'h38;
  localparam logic [7:0] OFS_STATUS   = 8'h3C;
  localparam logic [7:0] OFS_RESULT   = 8'h40;
  localparam logic [7:0] OFS_DIV1     = 8'h04;
  localparam logic [7:0] OFS_DIV2     = 8'h08;
  // control register fields
  localparam int CTRL_EXT   = 0;
  localparam int CTRL_PACER = 1;
  localparam int CTRL_INT   = 2;
  localparam int CTRL_DMA   = 3;
  // function register fields
  localparam int FUNC_BS    = 3;
  localparam int FUNC_BURST_MODE  = 4;
  localparam int FUNC_SAMPLE_HOLD = 5;
  // status flag positions, shared with enables
  localparam int IRQ_TIMER  = 3;
  localparam int IRQ_WINDOW = 2;
  localparam int IRQ_HFULL  = 1;
  localparam int IRQ_EXT_DIGITAL = 0;
  localparam int ST_READY   = 0;
  // timing
  localparam int CLK_MHZ      = 10;
  localparam int CONV_MAX_NS  = 8000;
  localparam int CONV_CYCLES  = 60;
  localparam int CONV_LIMIT   = CONV_MAX_NS * CLK_MHZ / 1000;
  // base counter clock 4 MHz from 10 MHz: alternate 2 and 3 cycles
  localparam logic [1:0] BASE_DIV_A = 2'h2;
  localparam logic [1:0] BASE_DIV_B = 2'h3;
  localparam logic [15:0] DIV_RESET = 16'h0004;

  typedef struct packed {
    logic [7:0]  addr;
    logic        wr;
    logic        rd;
    logic [31:0] wdata;
  } adcts_bus_t;

  typedef enum logic [1:0] {XFER_POLL, XFER_INT, XFER_DMA} adcts_xfer_t;
endpackage : adcts_pkg

/* rtl/adcts_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
module adcts_sequencer #(
  parameter int DW = 16,
  parameter int NW = 8
) (
  input  wire logic               i_clk_sys,
  input  wire logic               i_reset_n,
  input  wire adcts_pkg::adcts_bus_t i_bus,
  output logic [31:0]             o_rdata,
  input  wire logic               i_external_trigger_input,
  input  wire logic               i_conv_done,
  input  wire logic [15:0]        i_conv_data,
  input  wire logic               i_timer_event,
  input  wire logic               i_window_done,
  input  wire logic               i_fifo_half_full,
  input  wire logic               i_ext_digital_trigger,
  input  wire logic               i_fifo_ready,
  output logic                    o_conv_start,
  output logic                    o_hold_strobe,
  output logic                    o_fifo_valid,
  output logic [15:0]             o_fifo_data,
  output logic                    o_irq
);
  typedef enum logic [1:0] {S_IDLE, S_HOLD, S_CONV, S_WAIT} adcts_state_t;

  logic [3:0]  ctrl_r;
  logic [5:0]  func_r;
  logic [3:0]  irq_en_r;
  logic [3:0]  flags_r;
  logic [3:0]  flags_nxt;
  logic [DW-1:0] div1_r;
  logic [DW-1:0] div2_r;
  logic [NW-1:0] burst_num_r;
  logic [NW-1:0] chan_left_r;
  logic [15:0] result_r;
  logic        ready_r;
  logic        conv_irq_r;
  logic [6:0]  conv_cnt_r;
  logic [1:0]  base_cnt_r;
  logic        base_phase_r;
  logic        base_tick;
  logic        c1_pulse;
  logic        c2_pulse;
  logic [2:0]  ext_sync_r;
  logic [3:0]  ev_meta_r;
  logic [3:0]  ev_sync_r;
  logic [3:0]  ev_prev_r;
  logic        conv_meta_r;
  logic        conv_sync_r;
  logic        conv_prev_r;
  adcts_state_t state_r;
  adcts_state_t state_nxt;

  wire sel_ext    = ctrl_r[adcts_pkg::CTRL_EXT];
  wire sel_pacer  = ctrl_r[adcts_pkg::CTRL_PACER];
  wire burst_on   = func_r[adcts_pkg::FUNC_BURST_MODE] && func_r[adcts_pkg::FUNC_BS];
  wire burst_hold = burst_on && func_r[adcts_pkg::FUNC_SAMPLE_HOLD];
  wire wr_ctrl    = i_bus.wr && i_bus.addr == adcts_pkg::OFS_CTRL;
  wire wr_func    = i_bus.wr && i_bus.addr == adcts_pkg::OFS_FUNC;
  wire wr_irq     = i_bus.wr && i_bus.addr == adcts_pkg::OFS_IRQ;
  wire wr_swtrig  = i_bus.wr && i_bus.addr == adcts_pkg::OFS_SWTRIG;
  wire wr_bnum    = i_bus.wr && i_bus.addr == adcts_pkg::OFS_BURSTNUM;
  wire wr_div1    = i_bus.wr && i_bus.addr == adcts_pkg::OFS_DIV1;
  wire wr_div2    = i_bus.wr && i_bus.addr == adcts_pkg::OFS_DIV2;
  wire rd_irq     = i_bus.rd && i_bus.addr == adcts_pkg::OFS_IRQ;
  wire rd_result  = i_bus.rd && i_bus.addr == adcts_pkg::OFS_RESULT;
  wire ext_rise   = ext_sync_r[1] && !ext_sync_r[2];
  wire conv_end   = conv_sync_r && !conv_prev_r;
  wire [3:0] ev_rise = ev_sync_r & ~ev_prev_r;
  // external select masks both internal sources
  wire sw_trig    = !sel_ext && !sel_pacer && wr_swtrig;
  wire pace_trig  = !sel_ext && sel_pacer && c2_pulse;
  wire ext_trig   = sel_ext && ext_rise;
  wire trig       = sw_trig || pace_trig || ext_trig;
  wire busy       = state_r != S_IDLE;
  wire conv_tick  = burst_on ? c1_pulse : 1'b1;
  adcts_pkg::adcts_xfer_t xfer;
  assign xfer = ctrl_r[adcts_pkg::CTRL_DMA] ? adcts_pkg::XFER_DMA :
                ctrl_r[adcts_pkg::CTRL_INT] ? adcts_pkg::XFER_INT :
                                              adcts_pkg::XFER_POLL;

  // 4 MHz base from 10 MHz: periods of 2 and 3 clocks alternate
  assign base_tick = base_cnt_r == (base_phase_r ? adcts_pkg::BASE_DIV_B
                                                 : adcts_pkg::BASE_DIV_A) - 2'h1;

  adcts_divider #(.W(DW)) u_div1 (
    .i_clk_sys (i_clk_sys),
    .i_reset_n (i_reset_n),
    .i_tick    (base_tick),
    .i_clear   (wr_div1),
    .i_div     (div1_r),
    .o_pulse   (c1_pulse)
  );
  adcts_divider #(.W(DW)) u_div2 (
    .i_clk_sys (i_clk_sys),
    .i_reset_n (i_reset_n),
    .i_tick    (c1_pulse),
    .i_clear   (wr_div2),
    .i_div     (div2_r),
    .o_pulse   (c2_pulse)
  );

  // flags: a new event wins over a clearing read
  assign flags_nxt = (rd_irq ? 4'h0 : flags_r) | ev_rise;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      S_IDLE: if (trig) state_nxt = burst_hold ? S_HOLD : S_CONV;
      S_HOLD: if (c1_pulse) state_nxt = S_CONV;
      S_CONV: if (conv_tick) state_nxt = S_WAIT;
      S_WAIT: if (conv_end || conv_cnt_r == 7'(adcts_pkg::CONV_CYCLES)) begin
        state_nxt = (burst_on && chan_left_r > NW'(1)) ? S_CONV : S_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ext_sync_r  <= 3'h0;
      ev_meta_r   <= 4'h0;
      ev_sync_r   <= 4'h0;
      ev_prev_r   <= 4'h0;
      conv_meta_r <= 1'b0;
      conv_sync_r <= 1'b0;
      conv_prev_r <= 1'b0;
    end else begin
      ext_sync_r  <= {ext_sync_r[1:0], i_external_trigger_input};
      ev_meta_r   <= {i_timer_event, i_window_done, i_fifo_half_full, i_ext_digital_trigger};
      ev_sync_r   <= ev_meta_r;
      ev_prev_r   <= ev_sync_r;
      conv_meta_r <= i_conv_done;
      conv_sync_r <= conv_meta_r;
      conv_prev_r <= conv_sync_r;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ctrl_r      <= 4'h0;
      func_r      <= 6'h00;
      irq_en_r    <= 4'h0;
      flags_r     <= 4'h0;
      div1_r      <= DW'(adcts_pkg::DIV_RESET);
      div2_r      <= DW'(adcts_pkg::DIV_RESET);
      burst_num_r <= NW'(1);
    end else begin
      if (wr_ctrl) ctrl_r <= i_bus.wdata[3:0];
      if (wr_func) func_r <= i_bus.wdata[5:0];
      if (wr_irq)  irq_en_r <= i_bus.wdata[3:0];
      if (wr_div1) div1_r <= i_bus.wdata[DW-1:0];
      if (wr_div2) div2_r <= i_bus.wdata[DW-1:0];
      if (wr_bnum) burst_num_r <= i_bus.wdata[NW-1:0];
      flags_r <= flags_nxt;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      base_cnt_r   <= 2'h0;
      base_phase_r <= 1'b0;
      state_r      <= S_IDLE;
      conv_cnt_r   <= 7'h00;
      chan_left_r  <= '0;
    end else begin
      base_cnt_r   <= base_tick ? 2'h0 : base_cnt_r + 2'h1;
      base_phase_r <= base_tick ? !base_phase_r : base_phase_r;
      state_r      <= state_nxt;
      conv_cnt_r   <= (state_r == S_WAIT) ? conv_cnt_r + 7'h01 : 7'h00;
      if (state_r == S_IDLE && trig) chan_left_r <= burst_num_r;
      else if (state_r == S_WAIT && state_nxt != S_WAIT) chan_left_r <= chan_left_r - NW'(1);
    end
  end

  // conversion completes on the converter's done or the timeout cap
  wire conv_fin = state_r == S_WAIT && state_nxt != S_WAIT;

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ready_r       <= 1'b0;
      result_r      <= 16'h0000;
      o_conv_start  <= 1'b0;
      o_hold_strobe <= 1'b0;
      o_fifo_valid  <= 1'b0;
      o_fifo_data   <= 16'h0000;
      conv_irq_r    <= 1'b0;
      o_rdata       <= 32'h0000_0000;
    end else begin
      // finish wins over the clearing read of the low byte
      if (state_r == S_CONV || conv_fin) ready_r <= conv_fin;
      else if (rd_result) ready_r <= 1'b0;
      if (conv_fin) result_r <= i_conv_data;
      o_conv_start  <= state_r == S_CONV && conv_tick;
      o_hold_strobe <= state_r == S_HOLD;
      // fifo side stalls only via ready; no buffer is kept here
      if (conv_fin && xfer == adcts_pkg::XFER_DMA) begin
        o_fifo_valid <= 1'b1;
        o_fifo_data  <= i_conv_data;
      end else if (i_fifo_ready) o_fifo_valid <= 1'b0;
      if (conv_fin && xfer == adcts_pkg::XFER_INT) conv_irq_r <= 1'b1;
      else if (rd_result) conv_irq_r <= 1'b0;
      unique case (i_bus.addr)
        adcts_pkg::OFS_IRQ:    o_rdata <= {28'h0, flags_r};
        adcts_pkg::OFS_STATUS: o_rdata <= {30'h0, busy, ready_r};
        adcts_pkg::OFS_RESULT: o_rdata <= {16'h0, result_r};
        default:               o_rdata <= 32'h0000_0000;
      endcase
    end
  end

  assign o_irq = |(flags_r & irq_en_r) || conv_irq_r;

  sequence s_trig_ext;
    sel_ext && (wr_swtrig || c2_pulse) && !ext_rise && !busy;
  endsequence
  a_ext_masks_int: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    s_trig_ext |=> state_r == S_IDLE)
    else $error("internal trigger accepted under external select");
  a_ready_clear: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    rd_result && !conv_fin && state_r != S_CONV |=> !ready_r)
    else $error("ready flag not cleared by result read");
  a_ready_busy: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    state_r == S_CONV |=> !ready_r)
    else $error("ready set during conversion");
  a_conv_bound: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    conv_cnt_r <= 7'(adcts_pkg::CONV_LIMIT))
    else $error("conversion exceeds time limit");
  a_sw_start: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    sw_trig && !busy && !burst_on |=> state_r == S_CONV ##1 o_conv_start)
    else $error("software trigger did not start conversion");
  a_hold_first: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    trig && !busy && burst_hold |=> state_r == S_HOLD ##1 o_hold_strobe)
    else $error("sample-hold tick missing");
  a_irq_gate: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    o_irq == (|(flags_r & irq_en_r) || conv_irq_r))
    else $error("interrupt request not gated by enables");
  a_flag_hold: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    flags_r[adcts_pkg::IRQ_TIMER] && !rd_irq |=> flags_r[adcts_pkg::IRQ_TIMER])
    else $error("status flag lost before clear");
  a_ext_edge: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    ext_trig && !busy |=> busy)
    else $error("external edge did not start conversion");
endmodule : adcts_sequencer
`default_nettype wire

/* tb/adcts_conv_model.sv */
`timescale 1ns/1ps
`default_nettype none
// converter stand-in: answers each start after a chosen number of cycles
module adcts_conv_model (
  input  wire logic        i_clk_sys,
  input  wire logic        i_reset_n,
  input  wire logic        i_start,
  input  wire logic [7:0]  i_delay,
  input  wire logic [15:0] i_value,
  output logic             o_done,
  output logic [15:0]      o_data
);
  logic [7:0] cnt_r;
  logic       busy_r;
  // data is only valid from done to the next start; inverted meanwhile
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt_r <= 8'h00;
      busy_r <= 1'b0;
      o_done <= 1'b0;
      o_data <= 16'h0000;
    end else if (i_start) begin
      busy_r <= 1'b1;
      cnt_r <= i_delay;
      o_done <= 1'b0;
      o_data <= ~o_data;
    end else if (busy_r && cnt_r == 8'h00) begin
      busy_r <= 1'b0;
      o_done <= 1'b1;
      o_data <= i_value;
    end else if (busy_r) begin
      cnt_r <= cnt_r - 8'h01;
    end
  end
endmodule // adcts_conv_model
`default_nettype wire

/* tb/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic                  clk = 1'b0;
  logic                  rst_n = 1'b0;
  logic                  ext = 1'b0;
  logic                  fifo_rdy = 1'b0;
  logic [3:0]            ev = 4'h0;
  adcts_pkg::adcts_bus_t bus = '0;
  logic [31:0]           rdata;
  logic [31:0]           d;
  logic                  start, hold, fv, irq, done;
  logic [15:0]           fdata, cdata;
  logic [15:0]           val = 16'h0000;
  logic [7:0]            dly = 8'h0A;
  int                    mismatches = 0;
  int                    checks = 0;
  int                    n;
  time                   t0;

  always #50 clk = ~clk;

  adcts_sequencer uut (.i_clk_sys(clk), .i_reset_n(rst_n), .i_bus(bus), .o_rdata(rdata),
    .i_external_trigger_input(ext), .i_conv_done(done), .i_conv_data(cdata),
    .i_timer_event(ev[3]), .i_window_done(ev[2]), .i_fifo_half_full(ev[1]),
    .i_ext_digital_trigger(ev[0]), .i_fifo_ready(fifo_rdy), .o_conv_start(start),
    .o_hold_strobe(hold), .o_fifo_valid(fv), .o_fifo_data(fdata), .o_irq(irq));
  adcts_conv_model conv (.i_clk_sys(clk), .i_reset_n(rst_n), .i_start(start),
    .i_delay(dly), .i_value(val), .o_done(done), .o_data(cdata));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(negedge clk);
    bus.addr = a;
    bus.wdata = v;
    bus.wr = 1'b1;
    @(negedge clk);
    bus.wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(negedge clk);
    bus.addr = a;
    bus.rd = 1'b1;
    @(negedge clk);
    bus.rd = 1'b0;
    v = rdata;
  endtask
  task automatic wait_hi(ref logic s, input int lim, output int k);
    k = 0;
    while (s !== 1'b1 && k < lim) begin
      @(negedge clk);
      k++;
    end
  endtask
  // software trigger with fresh random result and converter delay
  task automatic trig(input logic [31:0] ctrl);
    wr(adcts_pkg::OFS_CTRL, ctrl);
    val = 16'($urandom);
    dly = 8'h05 + 8'($urandom % 40);
    t0 = $time;
    wr(adcts_pkg::OFS_SWTRIG, $urandom);
    wait_hi(start, 10, n);
    check({31'h0, start}, 32'h1);
  endtask
  task automatic summarize;
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    #(40000 * 100);
    mismatches++;
    summarize();
  end

  initial begin
    void'($urandom(32'hA4F7));
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    rd(adcts_pkg::OFS_IRQ, d);
    check(d, 32'h0);
    rd(8'h7C, d);
    check(d, 32'h0);
    // each flag masked by the other enables, then passed to irq by its own
    for (int i = 0; i < 4; i++) begin
      for (int ph = 0; ph < 2; ph++) begin
        wr(adcts_pkg::OFS_IRQ, ph ? (32'h1 << i) : (32'hF ^ (32'h1 << i)));
        ev[i] = 1'b1;
        repeat (2) @(negedge clk);
        ev[i] = 1'b0;
        repeat (6) @(negedge clk);
        check({31'h0, irq}, {31'h0, ph[0]});
        rd(adcts_pkg::OFS_IRQ, d);
        check(d, 32'h1 << i);
        rd(adcts_pkg::OFS_IRQ, d);
        check(d, 32'h0);
        check({31'h0, irq}, 32'h0);
      end
    end
    wr(adcts_pkg::OFS_IRQ, 32'h0);
    // polled transfers with random results and converter delays
    repeat (4) begin
      trig(32'h0);
      rd(adcts_pkg::OFS_STATUS, d);
      check({31'h0, d[adcts_pkg::ST_READY]}, 32'h0);
      n = 0;
      while (d[adcts_pkg::ST_READY] !== 1'b1 && n < 50) begin
        rd(adcts_pkg::OFS_STATUS, d);
        n++;
      end
      check({31'h0, ($time - t0) <= 64'd8000}, 32'h1);
      rd(adcts_pkg::OFS_RESULT, d);
      check({16'h0, d[15:0]}, {16'h0, val});
      rd(adcts_pkg::OFS_STATUS, d);
      check({31'h0, d[adcts_pkg::ST_READY]}, 32'h0);
    end
    trig(32'h1 << adcts_pkg::CTRL_INT);
    wait_hi(irq, 80, n);
    check({31'h0, irq}, 32'h1);
    rd(adcts_pkg::OFS_RESULT, d);
    @(negedge clk);
    check({31'h0, irq}, 32'h0);
    // bus-master: far side stalls before taking the word
    trig(32'h1 << adcts_pkg::CTRL_DMA);
    wait_hi(fv, 80, n);
    repeat (3) @(negedge clk);
    check({15'h0, fv, fdata}, {15'h0, 1'b1, val});
    fifo_rdy = 1'b1;
    @(negedge clk);
    fifo_rdy = 1'b0;
    @(negedge clk);
    check({31'h0, fv}, 32'h0);
    wr(adcts_pkg::OFS_DIV1, 32'h2);
    wr(adcts_pkg::OFS_DIV2, 32'h2);
    wr(adcts_pkg::OFS_CTRL, 32'h3);
    wr(adcts_pkg::OFS_SWTRIG, 32'h5A);
    wait_hi(start, 40, n);
    check({31'h0, start}, 32'h0);
    ext = 1'b1;
    wait_hi(start, 10, n);
    check({31'h0, start}, 32'h1);
    ext = 1'b0;
    // pacer period of c1*c2 base ticks, 2.5 system cycles each
    wr(adcts_pkg::OFS_DIV1, 32'h4);
    wr(adcts_pkg::OFS_DIV2, 32'h8);
    wr(adcts_pkg::OFS_CTRL, 32'h1 << adcts_pkg::CTRL_PACER);
    wait_hi(start, 200, n);
    @(negedge clk);
    wait_hi(start, 200, n);
    check(n + 1, 32'd80);
    wait_hi(hold, 80, n);
    check({31'h0, hold}, 32'h0);
    // two channels in sample-hold burst mode: the hold strobe must show within 300 cycles
    wr(adcts_pkg::OFS_BURSTNUM, 32'h2);
    wr(adcts_pkg::OFS_FUNC, 32'h38);
    wait_hi(hold, 300, n);
    check({31'h0, hold}, 32'h1);
    // burst starts fall on the c1 grid of 10 system cycles
    wait_hi(start, 40, n);
    @(negedge clk);
    wait_hi(start, 100, n);
    check((n + 1) % 10, 32'd0);
    check({31'h0, start}, 32'h1);
    wr(adcts_pkg::OFS_FUNC, 32'h0);
    wr(adcts_pkg::OFS_CTRL, 32'h0);
    summarize();
  end
endmodule // testbench
`default_nettype wire
